//--- pmu_consts.svh
`ifndef PMU_CONSTS_SVH
`define PMU_CONSTS_SVH
// Register byte addresses (APB)
`define PMU_ADDR_CTRL_A 12'h000
`define PMU_ADDR_CTRL_B 12'h004
`define PMU_ADDR_STATUS 12'h008
// Control A field positions
`define PMU_A_APD_OK 0
`define PMU_A_POL 1
`define PMU_A_AUTO_DOWN_ENABLE_BIT 2
`define PMU_A_MISER 3
`define PMU_A_TURBO_OFF 4
`define PMU_A_ACLK_OFF 5
`define PMU_A_RCLK_OFF 6
`define PMU_A_TMR_OFF 7
// Control B field positions
`define PMU_B_CLK_SEL 0
`define PMU_B_SLEEP_EN 1
// Reset values
`define PMU_CTRL_A_RST 8'h00
`define PMU_CTRL_B_RST 8'h00
// Counter overflow count
`define PMU_APD_OVF 4'hf
// Logic array idle time before power down
`define PMU_IDLE_NS 100
`define PMU_CLK_NS 8
`define PMU_IDLE_CYC ((`PMU_IDLE_NS + `PMU_CLK_NS - 1) / `PMU_CLK_NS)
`endif

//--- pmu_pkg.sv
package pmu_pkg;
  typedef enum logic [1:0] {PMU_ACTIVE, PMU_PDOWN, PMU_SLEEP} pmu_state_e;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } pmu_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pmu_apb_rsp_s;
  typedef struct packed {
    logic array_clk_en;
    logic macro_clk_en;
    logic timer_clk_en;
    logic external_clock_input_buf_en;
  } pmu_clk_gate_s;
endpackage

//--- pmu_apd_counter.sv
`timescale 1ns/1ns
`include "pmu_consts.svh"
// Automatic power-down counter, advanced on counter clock edges
module pmu_apd_counter (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_count_tick,
  input wire logic i_clear,
  output logic o_overflow
);
  logic [3:0] count_reg;

  // Count, clear, and flag overflow after 15 ticks
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      count_reg <= 4'h0;
      o_overflow <= 1'b0;
    end else if (i_ce) begin
      if (i_clear) begin
        count_reg <= 4'h0; // RQ22
        o_overflow <= 1'b0;
      end else if (i_count_tick && !o_overflow) begin
        count_reg <= count_reg + 4'h1; // RQ3
        if (count_reg == `PMU_APD_OVF - 4'h1) begin
          o_overflow <= 1'b1; // RQ3
        end
      end
    end
  end
endmodule

//--- pmu_top.sv
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`include "pmu_consts.svh"
// How it works
// (RQ1) Select high forces power down immediately
// (RQ2) Deselected: bus buffers off, array inputs blocked
// (RQ3) Idle latch strobe: 4-bit counter overflows at 15
// (RQ4) Sleep enable turns overflow into sleep
// (RQ5) Strobe activity exits automatic power down
// (RQ6) Control B bit 0 picks counter clock
// (RQ7) Host keeps under 15 clocks between strobes
// (RQ8) Control A bit 1 sets idle polarity
// (RQ9) Control A bit 2 enables automatic unit
// (RQ10) Software sets A bit 0, B upper zeros
// (RQ11) Sleep needs sleep, enable, polarity, overflow
// (RQ12) Sleep keeps timers, interrupts, array alive
// (RQ13) Miser clear: memory on while selected
// (RQ14) Miser set: memory standby unless addressed
// (RQ15) Miser and 8-bit bus: half arrays
// (RQ16) Turbo off: array sleeps after 100 ns idle
// (RQ17) A bit 5 gates array clock
// (RQ18) A bit 6 gates macrocell clock
// (RQ19) A bit 7 gates timer clock
// (RQ20) Counter clock gated in automatic standby
// (RQ21) Clock buffer off when 5-7 set, overflow
// (RQ22) Counter clears on every strobe edge
module pmu_top (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire pmu_pkg::pmu_apb_req_s i_apb,
  output pmu_pkg::pmu_apb_rsp_s o_apb,
  input wire logic i_select_n,
  input wire logic i_ale,
  input wire logic i_port_e_pin7_input,
  input wire logic i_external_clock_input,
  input wire logic i_array_inputs_changed,
  input wire logic i_eprom_addressed,
  input wire logic i_sram_addressed,
  input wire logic i_byte_bus,
  input wire logic i_addr_odd,
  output logic o_power_down_signal,
  output logic o_sleep,
  output logic o_bus_buffer_en,
  output logic o_array_input_en,
  output logic o_eprom_active,
  output logic o_mem_odd_en,
  output logic o_mem_even_en,
  output logic o_array_powered,
  output pmu_pkg::pmu_clk_gate_s o_clk_gate,
  output logic o_timers_run,
  output logic o_intc_run
);
  import pmu_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] power_mode_control_a_reg;
  logic [7:0] power_mode_control_b_reg;
  pmu_state_e state_reg;
  pmu_state_e state_next;
  logic ale_d_reg;
  logic cnt_clk_d_reg;
  logic ext_clk_d_reg;
  logic overflow;
  logic ale_edge;
  logic cnt_clk;
  logic cnt_tick;
  logic at_idle;
  logic deselected;
  logic auto_standby;
  logic [4:0] idle_cnt_reg;
  logic apb_access;
  logic [31:0] rdata;
  logic latch_idle_polarity;
  logic auto_down_enable_bit;
  logic memory_low_power_select;
  logic logic_array_fast_mode_off;
  logic array_clock_gate;
  logic macrocell_clock_gate;
  logic timer_clock_gate;
  logic sleep_enable;
  logic auto_down_counter_clock_sel;

  // Field views of the control registers
  assign latch_idle_polarity = power_mode_control_a_reg[`PMU_A_POL]; // RQ8
  assign auto_down_enable_bit = power_mode_control_a_reg[`PMU_A_AUTO_DOWN_ENABLE_BIT]; // RQ9
  assign memory_low_power_select = power_mode_control_a_reg[`PMU_A_MISER];
  assign logic_array_fast_mode_off = power_mode_control_a_reg[`PMU_A_TURBO_OFF];
  assign array_clock_gate = power_mode_control_a_reg[`PMU_A_ACLK_OFF];
  assign macrocell_clock_gate = power_mode_control_a_reg[`PMU_A_RCLK_OFF];
  assign timer_clock_gate = power_mode_control_a_reg[`PMU_A_TMR_OFF];
  assign sleep_enable = power_mode_control_b_reg[`PMU_B_SLEEP_EN];
  assign auto_down_counter_clock_sel = power_mode_control_b_reg[`PMU_B_CLK_SEL];

  // ----------------------------------------------------------------
  // APB register slave
  // ----------------------------------------------------------------
  assign apb_access = i_apb.psel && i_apb.penable;

  // Read mux, status word shows the select input and the block's own state
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (i_apb.paddr)
      `PMU_ADDR_CTRL_A: rdata = {24'h00_0000, power_mode_control_a_reg};
      `PMU_ADDR_CTRL_B: rdata = {24'h00_0000, power_mode_control_b_reg};
      `PMU_ADDR_STATUS: rdata = {28'h000_0000, ~i_select_n, overflow,
                                 o_sleep, o_power_down_signal};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Control register writes, software keeps A bit 0 set and B high bits zero
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      power_mode_control_a_reg <= `PMU_CTRL_A_RST; // RQ13 RQ16
      power_mode_control_b_reg <= `PMU_CTRL_B_RST; // RQ6
    end else if (i_ce && apb_access && i_apb.pwrite && o_apb.pready) begin
      if (i_apb.paddr == `PMU_ADDR_CTRL_A) begin
        power_mode_control_a_reg <= i_apb.pwdata[7:0]; // RQ10
      end
      if (i_apb.paddr == `PMU_ADDR_CTRL_B) begin
        power_mode_control_b_reg <= i_apb.pwdata[7:0];
      end
    end
  end

  // One wait state: ready raised in the access phase, dropped after
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_apb <= '0;
    end else if (i_ce) begin
      o_apb.pready <= apb_access && !o_apb.pready;
      o_apb.pslverr <= apb_access && !o_apb.pready &&
                       (i_apb.paddr != `PMU_ADDR_CTRL_A) &&
                       (i_apb.paddr != `PMU_ADDR_CTRL_B) &&
                       (i_apb.paddr != `PMU_ADDR_STATUS);
      o_apb.prdata <= (apb_access && !o_apb.pready) ? rdata : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Automatic power-down counter
  // ----------------------------------------------------------------
  // Counter clock source mux
  assign cnt_clk = auto_down_counter_clock_sel ? i_external_clock_input
                                               : i_port_e_pin7_input; // RQ6
  assign ale_edge = (i_ale != ale_d_reg);
  assign at_idle = (i_ale == latch_idle_polarity) && !ale_edge; // RQ8
  assign auto_standby = (state_reg != PMU_ACTIVE) && overflow;
  // Tick on rising counter clock, gated while in automatic standby
  assign cnt_tick = cnt_clk && !cnt_clk_d_reg && auto_down_enable_bit && at_idle
                    && !auto_standby; // RQ9 RQ20

  // Edge history of the strobe and counter clock
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ale_d_reg <= 1'b0;
      cnt_clk_d_reg <= 1'b0;
      ext_clk_d_reg <= 1'b0;
    end else if (i_ce) begin
      ale_d_reg <= i_ale;
      cnt_clk_d_reg <= cnt_clk;
      ext_clk_d_reg <= i_external_clock_input; // Array wake watches this pin and the array input change flag
    end
  end

  pmu_apd_counter u_apd_counter (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_count_tick(cnt_tick),
    .i_clear(ale_edge || !auto_down_enable_bit), // RQ22 RQ5 RQ7
    .o_overflow(overflow)
  );

  // ----------------------------------------------------------------
  // Standby state machine
  // ----------------------------------------------------------------
  assign deselected = i_select_n; // RQ1

  // Next standby state
  always_comb begin
    state_next = PMU_ACTIVE;
    if (overflow && auto_down_enable_bit) begin
      if (sleep_enable && latch_idle_polarity) begin
        state_next = PMU_SLEEP; // RQ4 RQ11
      end else begin
        state_next = PMU_PDOWN; // RQ3
      end
    end else if (deselected) begin
      state_next = PMU_PDOWN; // RQ1
    end
  end

  // Standby state, strobe activity clears overflow and exits
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_reg <= PMU_ACTIVE;
    end else if (i_ce) begin
      state_reg <= state_next; // RQ5
    end
  end

  // Standby outputs
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_power_down_signal <= 1'b0;
      o_sleep <= 1'b0;
    end else if (i_ce) begin
      o_power_down_signal <= (state_next != PMU_ACTIVE); // RQ1 RQ3
      o_sleep <= (state_next == PMU_SLEEP); // RQ4
    end
  end

  // Bus buffers and array input gating follow select
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_bus_buffer_en <= 1'b0;
      o_array_input_en <= 1'b0;
    end else if (i_ce) begin
      o_bus_buffer_en <= !deselected; // RQ2
      o_array_input_en <= !deselected; // RQ2
    end
  end

  // ----------------------------------------------------------------
  // Memory power control
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_eprom_active <= 1'b0;
      o_mem_odd_en <= 1'b0;
      o_mem_even_en <= 1'b0;
    end else if (i_ce) begin
      if (deselected) begin
        o_eprom_active <= 1'b0; // RQ13
      end else if (memory_low_power_select) begin
        o_eprom_active <= i_eprom_addressed; // RQ14
      end else begin
        o_eprom_active <= 1'b1; // RQ13
      end
      if (memory_low_power_select && i_byte_bus) begin
        o_mem_odd_en <= (i_eprom_addressed || i_sram_addressed) && i_addr_odd; // RQ15
        o_mem_even_en <= (i_eprom_addressed || i_sram_addressed) && !i_addr_odd;
      end else begin
        o_mem_odd_en <= 1'b1;
        o_mem_even_en <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Logic array power and clock gating
  // ----------------------------------------------------------------
  // Idle timer for the logic array; clock edges wake it unless gated
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      idle_cnt_reg <= 5'h00;
      o_array_powered <= 1'b1;
    end else if (i_ce) begin
      if (!logic_array_fast_mode_off || i_array_inputs_changed ||
          (!array_clock_gate && ext_clk_d_reg != i_external_clock_input)) begin
        idle_cnt_reg <= 5'h00; // RQ17
        o_array_powered <= 1'b1;
      end else if (idle_cnt_reg == 5'(`PMU_IDLE_CYC)) begin
        o_array_powered <= 1'b0; // RQ16
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 5'h01;
      end
    end
  end

  // Clock gates; sleep leaves timers, interrupts and array running
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_clk_gate <= '0;
      o_timers_run <= 1'b0;
      o_intc_run <= 1'b0;
    end else if (i_ce) begin
      o_clk_gate.array_clk_en <= !array_clock_gate; // RQ17
      o_clk_gate.macro_clk_en <= !macrocell_clock_gate; // RQ18
      o_clk_gate.timer_clk_en <= !timer_clock_gate; // RQ19
      o_clk_gate.external_clock_input_buf_en <= !(array_clock_gate && macrocell_clock_gate &&
                                   timer_clock_gate && overflow); // RQ21
      o_timers_run <= !timer_clock_gate; // RQ12 RQ19
      o_intc_run <= 1'b1; // RQ12
    end
  end
endmodule

//--- pmu_host_model.sv
`timescale 1ns/1ns
// Host side: latch strobe and both counter clock sources
module pmu_host_model (
  input wire logic i_clk,
  input wire logic i_pulse,
  input wire logic i_idle,
  output logic o_ale,
  output logic o_pin7,
  output logic o_ext
);
  logic [1:0] ph_reg = 2'h0;
  // Strobe toggles each cycle while active, so no counter tick gap builds up
  always @(posedge i_clk) begin
    ph_reg <= ph_reg + 2'h1;
    o_ale <= i_pulse ? ph_reg[0] : i_idle;
    o_pin7 <= ph_reg[1];
    o_ext <= ph_reg[0];
  end
endmodule

//--- pmu_sva.sv
`timescale 1ns/1ns
// Port checker for the power management unit
module pmu_sva (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire pmu_pkg::pmu_apb_req_s i_apb,
  input wire pmu_pkg::pmu_apb_rsp_s o_apb,
  input wire logic i_select_n,
  input wire logic i_ale,
  input wire logic i_eprom_addressed,
  input wire logic o_power_down_signal,
  input wire logic o_sleep,
  input wire logic o_bus_buffer_en,
  input wire logic o_array_input_en,
  input wire logic o_eprom_active,
  input wire pmu_pkg::pmu_clk_gate_s o_clk_gate
);
  import pmu_pkg::*;
  logic [7:0] a_reg;
  logic [7:0] b_reg;
  logic wr;
  logic sl_ok;
  // ----
  // Shadow copies of the control registers
  // ----
  assign wr = i_apb.psel && i_apb.penable && i_apb.pwrite && o_apb.pready;
  assign sl_ok = a_reg[2] && a_reg[1] && b_reg[1];
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      a_reg <= 8'h00;
      b_reg <= 8'h00;
    end else if (wr && i_apb.paddr == 12'h000) begin
      a_reg <= i_apb.pwdata[7:0];
    end else if (wr && i_apb.paddr == 12'h004) begin
      b_reg <= i_apb.pwdata[7:0];
    end
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  property p_sel; i_select_n |=> o_power_down_signal; endproperty
  a_sel: assert property (p_sel) else $error("no standby on deselect");
  property p_bus; i_select_n |=> !o_bus_buffer_en && !o_array_input_en; endproperty
  a_bus: assert property (p_bus) else $error("buffers on while deselected");
  property p_off; (!a_reg[2] && !i_select_n) [*3] |=> !o_power_down_signal; endproperty
  a_off: assert property (p_off) else $error("standby with unit off");
  property p_slp; $rose(o_sleep) |-> $past(sl_ok); endproperty
  a_slp: assert property (p_slp) else $error("sleep without its bits");
  property p_wake; $changed(i_ale) && !i_select_n ##1 !i_select_n |=> !o_power_down_signal;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on strobe");
  property p_mis; a_reg[3] && !i_eprom_addressed |=> !o_eprom_active; endproperty
  a_mis: assert property (p_mis) else $error("memory on while idle");
  property p_mem; i_select_n |=> !o_eprom_active; endproperty
  a_mem: assert property (p_mem) else $error("memory on while deselected");
  property p_tmr; a_reg[7] |=> !o_clk_gate.timer_clk_en; endproperty
  a_tmr: assert property (p_tmr) else $error("timer clock not gated");
  c_sleep: cover property ($rose(o_sleep));
  c_down: cover property ($rose(o_power_down_signal) && !i_select_n);
  c_wake: cover property ($fell(o_sleep));
endmodule
bind pmu_top pmu_sva u_sva (.i_sys_clk, .i_sys_rst, .i_apb, .o_apb, .i_select_n, .i_ale,
  .i_eprom_addressed, .o_power_down_signal, .o_sleep, .o_bus_buffer_en, .o_array_input_en,
  .o_eprom_active, .o_clk_gate);

//--- pmu_bench.sv
`timescale 1ns/1ns
// Bench for the power management unit
module pmu_bench;
  import pmu_pkg::*;
  logic clk, rst, sel_n, pulse, idle, ea, bb, odd, chg, err;
  logic ale, pin7, ext, dn, slp, bus_en, ain_en, ep, oe, ee, ap, tr, ir;
  pmu_apb_req_s req;
  pmu_apb_rsp_s rsp;
  pmu_clk_gate_s g;
  logic [31:0] q;
  int mismatches;
  int n_tests;
  pmu_top dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_apb(req), .o_apb(rsp),
    .i_select_n(sel_n), .i_ale(ale), .i_port_e_pin7_input(pin7), .i_external_clock_input(ext),
    .i_array_inputs_changed(chg), .i_eprom_addressed(ea), .i_sram_addressed(1'b0),
    .i_byte_bus(bb), .i_addr_odd(odd), .o_power_down_signal(dn), .o_sleep(slp),
    .o_bus_buffer_en(bus_en), .o_array_input_en(ain_en), .o_eprom_active(ep),
    .o_mem_odd_en(oe), .o_mem_even_en(ee), .o_array_powered(ap), .o_clk_gate(g),
    .o_timers_run(tr), .o_intc_run(ir));
  pmu_host_model host (.i_clk(clk), .i_pulse(pulse), .i_idle(idle), .o_ale(ale),
    .o_pin7(pin7), .o_ext(ext));
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----
  // Tasks
  // ----
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] v);
    n_tests++;
    if (v !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, v);
    end
  endtask
  task automatic fl(input logic [3:0] e, input logic [3:0] v);
    chk({28'h000_0000, e}, {28'h000_0000, v});
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bus cycle: setup, access until ready, then one idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    req <= '{a, 1'b1, 1'b0, w, {24'h00_0000, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (k >= 20) begin
      mismatches++;
      report_and_stop();
    end
    @(posedge clk);
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    {rst, sel_n, pulse, idle, ea, bb, odd, chg} = 8'ha1;
    req = '0;
    cy(4);
    rst <= 1'b0;
    cy(1);
    apb(1'b0, 12'h000, 8'h00);
    chk(32'h0000_0000, q);
    apb(1'b0, 12'h004, 8'h00);
    chk(32'h0000_0000, q);
    apb(1'b0, 12'h00c, 8'h00);
    fl(4'h1, err);
    sel_n <= 1'b1;
    cy(2);
    fl(4'h1, {bus_en, ain_en, dn});
    sel_n <= 1'b0;
    apb(1'b1, 12'h000, 8'h07);
    cy(80);
    fl(4'h0, dn);
    pulse <= 1'b0;
    idle <= 1'b1;
    cy(40);
    fl(4'h0, dn);
    cy(30);
    fl(4'h1, {slp, dn});
    apb(1'b0, 12'h008, 8'h00);
    chk(32'h0000_000d, q);
    pulse <= 1'b1;
    cy(5);
    fl(4'h0, dn);
    apb(1'b1, 12'h004, 8'h03);
    pulse <= 1'b0;
    cy(40);
    fl(4'hf, {slp, dn, tr, ir});
    pulse <= 1'b1;
    cy(5);
    fl(4'h0, {slp, dn});
    idle <= 1'b0;
    pulse <= 1'b0;
    cy(80);
    fl(4'h0, dn);
    apb(1'b1, 12'h000, 8'h05);
    cy(40);
    fl(4'h1, {slp, dn});
    pulse <= 1'b1;
    idle <= 1'b1;
    apb(1'b1, 12'h000, 8'he7);
    pulse <= 1'b0;
    cy(40);
    fl(4'h0, g);
    pulse <= 1'b1;
    cy(5);
    fl(4'h1, g);
    apb(1'b1, 12'h004, 8'h00);
    apb(1'b1, 12'h000, 8'h09);
    cy(2);
    fl(4'h0, ep);
    {ea, bb, odd} <= 3'h7;
    cy(2);
    fl(4'h6, {ep, oe, ee});
    odd <= 1'b0;
    cy(2);
    fl(4'h5, {ep, oe, ee});
    apb(1'b1, 12'h000, 8'h01);
    ea <= 1'b0;
    cy(2);
    fl(4'h1, ep);
    sel_n <= 1'b1;
    cy(2);
    fl(4'h0, ep);
    sel_n <= 1'b0;
    apb(1'b1, 12'h004, 8'h01);
    apb(1'b1, 12'h000, 8'h31);
    chg <= 1'b0;
    cy(11);
    fl(4'h1, ap);
    cy(6);
    fl(4'h0, ap);
    apb(1'b1, 12'h000, 8'h11);
    cy(3);
    fl(4'h1, ap);
    report_and_stop();
  end
endmodule
